//--- src/spc_port.sv
/*
  Serial control port with packet error code check and byte-wide register map.
  Assumes serial pins are asynchronous to clk and clk is well above the serial clock rate.
*/
// Function
// [RULE1] Chip select low frames a burst; only the low period counts as transfer.
// [RULE2] Input sampled on serial clock rising edges, most significant bit first.
// [RULE3] Data output released whenever chip select high or not returning read data.
// [RULE4] Read bursts return the addressed register on the data output.
// [RULE5] First byte: seven address bits, then read flag (1 read, 0 write).
// [RULE6] Burst holds address byte, data byte, then error code byte.
// [RULE7] Five read/write and six read-only byte registers.
// [RULE8] Write loads at falling edge of cycle 24, only with a valid code.
// [RULE9] Code is CRC-8, polynomial x^8+x^2+x+1, seeded 0x41, transmission order.
// [RULE10] Per bit: three taps from input and code bits, then shift left.
// [RULE11] Master computes write code, latches at fall 15, sends after data.
// [RULE12] Write code latched at rise 16, compared with received byte.
// [RULE13] Read code over address and returned data, latched at fall 15, sent after.
// [RULE14] Master checks read code latched at rise 16 before trusting data.
// [RULE15] Failed write check sets sticky fault flag, cleared by writing one.
// [RULE16] Write protect blocks writes to the three DAC and spread spectrum registers.
// [RULE17] Master uses separate chip selects, at most one active during reads.
// [RULE18] Short write bursts dropped; counter and code reseeded at each burst start.
// [RULE19] Data output changes on falling serial clock edges.
`timescale 1ns/1ps
module spc_port #(
  parameter int unsigned LOG_DEPTH = spc_pkg::LOG_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       chipSelectN,
  input  wire logic       serialClk,
  input  wire logic       serialDataIn,
  output logic            serialDataOut,
  output logic            serialDataOutEn,
  input  wire logic [7:0] faultSummary,
  input  wire logic [7:0] ocFaultSummary,
  input  wire logic [7:0] nocFaultSummary,
  input  wire logic [7:0] opStatus,
  input  wire logic [7:0] pinConfig1,
  input  wire logic [7:0] pinConfig2,
  output logic [7:0]      dacLow,
  output logic [7:0]      dacHigh,
  output logic [7:0]      dacCurrent,
  output logic [7:0]      spreadConfig,
  output logic            writeProtect,
  output logic            commFaultFlag,
  output logic            wrLogValid,
  input  wire logic       wrLogReady,
  output logic [6:0]      wrLogAddr,
  output logic [7:0]      wrLogData
);

  logic [2:0]              sclkSync_ff;
  logic [2:0]              csnSync_ff;
  logic [1:0]              sdiSync_ff;
  logic                    csnHigh;
  logic                    sclkRise;
  logic                    sclkFall;
  logic                    burstStart;
  logic                    sdiBit;
  logic [4:0]              bitCnt_ff;
  logic [4:0]              nxt_bitCnt;
  spc_pkg::spc_phase_t     phase_ff;
  logic [7:0]              rxShift_ff;
  logic [7:0]              nxt_rxByte;
  logic [7:0]              addrByte_ff;
  logic [7:0]              dataByte_ff;
  logic [7:0]              rxPec_ff;
  logic [7:0]              crc_ff;
  logic [7:0]              calcPec_ff;
  logic [7:0]              txShift_ff;
  logic                    sdoOut_ff;
  logic                    sdoOe_ff;
  logic                    txBit;
  logic [7:0]              txLoad;
  logic                    txLoadNow;
  logic                    isRead;
  logic [6:0]              regAddr;
  logic [7:0]              readData;
  logic                    commitEvt;
  logic                    pecOk;
  logic                    logReady;
  logic                    regWrite;
  logic                    badPec;
  logic                    ctrlWrite;
  logic                    protectHit;
  logic [7:0]              dacReg_ff [spc_pkg::DAC_COUNT];
  logic                    wp_ff;
  logic                    commFault_ff;

  // Synchronisers: stage one feeds only stage two; stage three is edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkSync_ff <= 3'h0;
      csnSync_ff  <= 3'h7;
      sdiSync_ff  <= 2'h0;
    end else begin
      sclkSync_ff <= {sclkSync_ff[1:0], serialClk};
      csnSync_ff  <= {csnSync_ff[1:0], chipSelectN};
      sdiSync_ff  <= {sdiSync_ff[0], serialDataIn};
    end
  end

  assign csnHigh    = csnSync_ff[1];
  assign burstStart = ~csnSync_ff[1] & csnSync_ff[2];                 // [RULE1]
  assign sclkRise   = ~csnHigh & sclkSync_ff[1] & ~sclkSync_ff[2];    // [RULE1] [RULE2]
  assign sclkFall   = ~csnHigh & ~sclkSync_ff[1] & sclkSync_ff[2];    // [RULE1]
  assign sdiBit     = sdiSync_ff[1];
  assign nxt_bitCnt = bitCnt_ff + spc_pkg::CNT_ONE;
  assign nxt_rxByte = {rxShift_ff[6:0], sdiBit};                      // [RULE2]
  assign isRead     = addrByte_ff[0];                                 // [RULE5]
  assign regAddr    = addrByte_ff[7:1];                               // [RULE5]

  // Bit counter, reseeded each burst; saturates on over-long bursts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_ff <= spc_pkg::CNT_ZERO;
    end else if (burstStart) begin
      bitCnt_ff <= spc_pkg::CNT_ZERO;                                 // [RULE18]
    end else if (sclkRise && bitCnt_ff != spc_pkg::CNT_MAX) begin
      bitCnt_ff <= nxt_bitCnt;                                        // [RULE2]
    end
  end

  // Burst phase: address, data, code, then anything extra
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= spc_pkg::PH_IDLE;
    end else if (burstStart) begin
      phase_ff <= spc_pkg::PH_ADDR;
    end else if (csnHigh) begin
      phase_ff <= spc_pkg::PH_IDLE;                                   // [RULE1] [RULE18]
    end else if (sclkRise) begin
      unique case (phase_ff)
        spc_pkg::PH_IDLE: phase_ff <= spc_pkg::PH_IDLE;
        spc_pkg::PH_ADDR: begin
          if (nxt_bitCnt == spc_pkg::CNT_ADDR_END) begin
            phase_ff <= spc_pkg::PH_DATA;                             // [RULE6]
          end
        end
        spc_pkg::PH_DATA: begin
          if (nxt_bitCnt == spc_pkg::CNT_DATA_END) begin
            phase_ff <= spc_pkg::PH_PEC;                              // [RULE6]
          end
        end
        spc_pkg::PH_PEC: begin
          if (nxt_bitCnt == spc_pkg::CNT_PEC_END) begin
            phase_ff <= spc_pkg::PH_TAIL;                             // [RULE6]
          end
        end
        spc_pkg::PH_TAIL: phase_ff <= spc_pkg::PH_TAIL;
        default: phase_ff <= spc_pkg::PH_IDLE;
      endcase
    end
  end

  // Received bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_ff  <= spc_pkg::REG_RESET;
      addrByte_ff <= spc_pkg::REG_RESET;
      dataByte_ff <= spc_pkg::REG_RESET;
      rxPec_ff    <= spc_pkg::REG_RESET;
    end else if (sclkRise) begin
      rxShift_ff <= nxt_rxByte;
      if (phase_ff == spc_pkg::PH_ADDR && nxt_bitCnt == spc_pkg::CNT_ADDR_END) begin
        addrByte_ff <= nxt_rxByte;                                    // [RULE5]
      end
      if (phase_ff == spc_pkg::PH_DATA && nxt_bitCnt == spc_pkg::CNT_DATA_END) begin
        dataByte_ff <= nxt_rxByte;
      end
      if (phase_ff == spc_pkg::PH_PEC && nxt_bitCnt == spc_pkg::CNT_PEC_END) begin
        rxPec_ff <= nxt_rxByte;
      end
    end
  end

  // Error code: write data folded in on rises, read data on the falls that drive it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_ff     <= spc_pkg::PEC_INIT;
      calcPec_ff <= spc_pkg::PEC_INIT;
    end else if (burstStart) begin
      crc_ff <= spc_pkg::PEC_INIT;                                    // [RULE9] [RULE18]
    end else if (sclkRise && (phase_ff == spc_pkg::PH_ADDR ||
                              (phase_ff == spc_pkg::PH_DATA && !isRead))) begin
      crc_ff <= spc_pkg::spc_crc_step(crc_ff, sdiBit);                // [RULE9] [RULE10]
      if (phase_ff == spc_pkg::PH_DATA && nxt_bitCnt == spc_pkg::CNT_DATA_END) begin
        calcPec_ff <= spc_pkg::spc_crc_step(crc_ff, sdiBit);          // [RULE12]
      end
    end else if (sclkFall && phase_ff == spc_pkg::PH_DATA && isRead) begin
      crc_ff <= spc_pkg::spc_crc_step(crc_ff, txBit);                 // [RULE13]
      if (bitCnt_ff == spc_pkg::CNT_DATA_LAST) begin
        calcPec_ff <= spc_pkg::spc_crc_step(crc_ff, txBit);           // [RULE13]
      end
    end
  end

  // Read mux; unmapped and reserved addresses return zero
  always_comb begin
    readData = spc_pkg::READ_NONE;
    case (regAddr)
      spc_pkg::ADDR_FAULT:   readData = faultSummary;                 // [RULE7]
      spc_pkg::ADDR_OC:      readData = ocFaultSummary;
      spc_pkg::ADDR_NOC:     readData = nocFaultSummary;
      spc_pkg::ADDR_STATUS:  readData = opStatus;
      spc_pkg::ADDR_CONFIG1: readData = pinConfig1;
      spc_pkg::ADDR_CONFIG2: readData = pinConfig2;
      spc_pkg::ADDR_CTRL: begin
        readData[spc_pkg::CTRL_WP_BIT]    = wp_ff;
        readData[spc_pkg::CTRL_FAULT_BIT] = commFault_ff;
      end
      default: begin
        for (int i = 0; i < spc_pkg::DAC_COUNT; i++) begin
          if (regAddr == spc_pkg::ADDR_DAC0 + 7'(i)) begin
            readData = dacReg_ff[i];
          end
        end
      end
    endcase
  end

  // Transmit source: data byte at fall 8, code byte at fall 16
  assign txLoadNow = (bitCnt_ff == spc_pkg::CNT_ADDR_END) || (bitCnt_ff == spc_pkg::CNT_DATA_END);
  assign txLoad    = (bitCnt_ff == spc_pkg::CNT_ADDR_END) ? readData : calcPec_ff;
  assign txBit     = txLoadNow ? txLoad[7] : txShift_ff[7];

  // Output changes only on falls while chip select is low, so the master samples on the next rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_ff <= spc_pkg::REG_RESET;
      sdoOut_ff  <= 1'b0;
      sdoOe_ff   <= 1'b0;
    end else if (csnHigh) begin
      sdoOe_ff  <= 1'b0;                                              // [RULE3]
      sdoOut_ff <= 1'b0;
    end else if (sclkFall && isRead &&
                 (phase_ff == spc_pkg::PH_DATA || phase_ff == spc_pkg::PH_PEC)) begin
      sdoOut_ff  <= txBit;                                            // [RULE4] [RULE13] [RULE19]
      sdoOe_ff   <= 1'b1;
      txShift_ff <= txLoadNow ? {txLoad[6:0], 1'b0} : {txShift_ff[6:0], 1'b0};
    end else if (sclkFall) begin
      sdoOe_ff  <= 1'b0;                                              // [RULE3]
      sdoOut_ff <= 1'b0;
    end
  end

  // Gate on chip select directly so release does not wait for a fall
  assign serialDataOutEn = sdoOe_ff & ~csnHigh;                       // [RULE3]
  assign serialDataOut   = sdoOut_ff;

  // Commit at the 24th fall; an early chip select rise never reaches it
  assign commitEvt  = sclkFall && phase_ff == spc_pkg::PH_TAIL &&
                      bitCnt_ff == spc_pkg::CNT_PEC_END && !isRead;   // [RULE8] [RULE18]
  assign pecOk      = (rxPec_ff == calcPec_ff);                       // [RULE12]
  assign regWrite   = commitEvt & pecOk & logReady;                   // [RULE8]
  // A full change log refuses the write and reports it like a bad code
  assign badPec     = commitEvt & ~(pecOk & logReady);                // [RULE15]
  assign ctrlWrite  = regWrite && regAddr == spc_pkg::ADDR_CTRL;
  assign protectHit = wp_ff && regAddr >= spc_pkg::ADDR_DAC0 &&
                      regAddr < spc_pkg::ADDR_DAC0 + 7'(spc_pkg::DAC_COUNT);

  // DAC and spread spectrum registers
  generate
    for (genvar g = 0; g < spc_pkg::DAC_COUNT; g++) begin : gDac
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dacReg_ff[g] <= spc_pkg::REG_RESET;
        end else if (ctrlWrite && dataByte_ff[spc_pkg::CTRL_RST_BIT]) begin
          dacReg_ff[g] <= spc_pkg::REG_RESET;
        end else if (regWrite && !protectHit &&
                     regAddr == spc_pkg::ADDR_DAC0 + 7'(g)) begin
          dacReg_ff[g] <= dataByte_ff;                                // [RULE8] [RULE16]
        end
      end
    end
  endgenerate

  // Write protect and sticky fault; a fault set in the same cycle beats its clear, the reset bit beats the protect bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff        <= 1'b0;
      commFault_ff <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        wp_ff <= dataByte_ff[spc_pkg::CTRL_WP_BIT] & ~dataByte_ff[spc_pkg::CTRL_RST_BIT];
      end
      commFault_ff <= badPec |                                        // [RULE15]
                      (commFault_ff & ~(ctrlWrite & dataByte_ff[spc_pkg::CTRL_FAULT_BIT]));
    end
  end

  assign dacLow        = dacReg_ff[0];
  assign dacHigh       = dacReg_ff[1];
  assign dacCurrent    = dacReg_ff[2];
  assign spreadConfig  = dacReg_ff[3];
  assign writeProtect  = wp_ff;
  assign commFaultFlag = commFault_ff;

  // Log of accepted writes for the surrounding logic
  spc_fifo #(
    .WIDTH (spc_pkg::LOG_WIDTH),
    .DEPTH (LOG_DEPTH)
  ) uLog (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (regWrite),
    .inReady  (logReady),
    .inData   ({regAddr, dataByte_ff}),
    .outValid (wrLogValid),
    .outReady (wrLogReady),
    .outData  ({wrLogAddr, wrLogData})
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sdo_idle_hiz: assert property (                                   // [RULE3]
    (csnHigh || phase_ff == spc_pkg::PH_ADDR || !isRead) |-> !serialDataOutEn)
    else $error("data output driven outside read data");
  a_read_drives: assert property (                                    // [RULE4]
    sclkFall && isRead && phase_ff == spc_pkg::PH_DATA && bitCnt_ff == spc_pkg::CNT_ADDR_END
    |=> serialDataOutEn && serialDataOut == $past(readData[7]))
    else $error("read data not driven at fall 8");
  a_count_on_rise: assert property (                                  // [RULE2]
    !sclkRise && !burstStart |=> $stable(bitCnt_ff))
    else $error("bit count moved without a rising edge");
  a_crc_seeded: assert property (                                     // [RULE18]
    burstStart |=> crc_ff == spc_pkg::PEC_INIT && bitCnt_ff == spc_pkg::CNT_ZERO)
    else $error("burst start did not reseed");
  a_commit_at_24: assert property (                                   // [RULE8]
    regWrite |-> sclkFall && bitCnt_ff == spc_pkg::CNT_PEC_END && !isRead)
    else $error("register load outside the 24th fall");
  a_commit_pec_ok: assert property (                                  // [RULE12]
    regWrite |-> rxPec_ff == calcPec_ff)
    else $error("write accepted with a bad code");
  a_fault_sticky: assert property (                                   // [RULE15]
    badPec |=> commFault_ff ##1 (commFault_ff || $past(ctrlWrite)))
    else $error("fault flag not set on bad code");
  a_wp_holds: assert property (                                       // [RULE16]
    regWrite && protectHit |=> dacLow == $past(dacLow) && dacHigh == $past(dacHigh) &&
                               dacCurrent == $past(dacCurrent) && spreadConfig == $past(spreadConfig))
    else $error("protected register changed");
  a_sdo_on_fall: assert property (                                    // [RULE19]
    !sclkFall && !csnHigh |=> $stable(sdoOut_ff))
    else $error("data output changed off a falling edge");
  a_addr_flag: assert property (                                      // [RULE5]
    sclkRise && phase_ff == spc_pkg::PH_ADDR && bitCnt_ff == spc_pkg::CNT_ADDR_END - spc_pkg::CNT_ONE
    |=> addrByte_ff[0] == $past(sdiBit))
    else $error("read flag not taken from eighth bit");

  c_write_ok:  cover property (regWrite);
  c_bad_code:  cover property (badPec && logReady);
  c_read_done: cover property (sclkFall && isRead && bitCnt_ff == spc_pkg::CNT_PEC_END);
  c_log_full:  cover property (commitEvt && !logReady);

endmodule : spc_port

//--- inc/spc_pkg.sv
/*
  Shared constants, types and the packet error code step for the serial control port.
  Assumes a single system clock; the serial pins arrive asynchronously to it.
*/
package spc_pkg;

  // Bit counts within a burst, counted in serial clock rising edges
  localparam logic [4:0] CNT_ZERO      = 5'h00;
  localparam logic [4:0] CNT_ONE       = 5'h01;
  localparam logic [4:0] CNT_ADDR_END  = 5'h08;
  localparam logic [4:0] CNT_DATA_LAST = 5'h0F;
  localparam logic [4:0] CNT_DATA_END  = 5'h10;
  localparam logic [4:0] CNT_PEC_END   = 5'h18;
  localparam logic [4:0] CNT_MAX       = 5'h1F;

  localparam logic [7:0] PEC_INIT  = 8'h41;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  // Register map, 7-bit addresses
  localparam logic [6:0] ADDR_FAULT   = 7'h01;
  localparam logic [6:0] ADDR_OC      = 7'h02;
  localparam logic [6:0] ADDR_NOC     = 7'h03;
  localparam logic [6:0] ADDR_STATUS  = 7'h04;
  localparam logic [6:0] ADDR_CONFIG1 = 7'h05;
  localparam logic [6:0] ADDR_CONFIG2 = 7'h06;
  localparam logic [6:0] ADDR_CTRL    = 7'h07;
  localparam logic [6:0] ADDR_DAC0    = 7'h08;
  localparam int unsigned DAC_COUNT   = 4;

  // Control register fields
  localparam int unsigned CTRL_WP_BIT    = 0;
  localparam int unsigned CTRL_RST_BIT   = 1;
  localparam int unsigned CTRL_FAULT_BIT = 2;

  localparam int unsigned LOG_DEPTH = 4;
  localparam int unsigned LOG_WIDTH = 15;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_ADDR = 5'b00010,
    PH_DATA = 5'b00100,
    PH_PEC  = 5'b01000,
    PH_TAIL = 5'b10000
  } spc_phase_t;

  function automatic logic [7:0] spc_crc_step(input logic [7:0] crc, input logic din);
    logic crcTap0;
    logic crcTap1;
    logic crcTap2;
    crcTap0 = din ^ crc[7];
    crcTap1 = crc[0] ^ crcTap0;
    crcTap2 = crc[1] ^ crcTap0;
    return {crc[6:2], crcTap2, crcTap1, crcTap0};
  endfunction : spc_crc_step

endpackage : spc_pkg

//--- src/spc_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/1ps
module spc_fifo #(
  parameter int unsigned WIDTH = spc_pkg::LOG_WIDTH,
  parameter int unsigned DEPTH = spc_pkg::LOG_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic             push;
  logic             pop;

  assign inReady  = (count_ff != CW'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
      end
      if (pop) begin
        rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
      end
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

endmodule : spc_fifo

//--- test/spc_master.sv
/*
  Serial bus master model for the control port.
  Assumes clk is the bench clock; the data line is pulled up when released.
*/
`timescale 1ns/1ps
module spc_master (
  input  wire logic clk,
  output logic      chipSelectN,
  output logic      serialClk,
  output logic      serialDataIn,
  input  wire logic sdoLine
);
  initial begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    serialDataIn = 1'b0;
  end

  // Code over address byte and data byte
  function automatic logic [7:0] packet_error_code(input logic [15:0] d);
    logic [7:0] c;
    logic       t;
    c = 8'h41;
    for (int i = 15; i >= 0; i--) begin
      t = d[i] ^ c[7];
      c = {c[6:2], c[1] ^ t, c[0] ^ t, t};
    end
    return c;
  endfunction : packet_error_code

  // Half period of 4 clk, slow enough for the port's synchronisers
  task automatic burst(input logic [23:0] tx, input int nBits, output logic [23:0] rx);
    rx = '1;
    @(posedge clk);
    chipSelectN <= 1'b0;
    for (int i = 23; i > 23 - nBits; i--) begin
      serialDataIn <= tx[i];
      repeat (4) @(posedge clk);
      rx[i] = sdoLine;
      serialClk <= 1'b1;
      repeat (4) @(posedge clk);
      serialClk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    chipSelectN <= 1'b1;
    serialDataIn <= ~serialDataIn;
    repeat (4) @(posedge clk);
  endtask : burst
endmodule : spc_master

//--- test/spc_port_test.sv
/*
  Self-checking bench for the serial control port, one task per scenario.
  Assumes the master model drives the serial pins; the data line has a pull-up.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module spc_port_test;
  logic       clk;
  logic       rst_n;
  logic       chipSelectN;
  logic       serialClk;
  logic       serialDataIn;
  logic       serialDataOut;
  logic       serialDataOutEn;
  logic       writeProtect;
  logic       commFaultFlag;
  logic       wrLogValid;
  logic       wrLogReady;
  logic [6:0] wrLogAddr;
  logic [7:0] wrLogData;
  logic [7:0] roReg [6];
  logic [7:0] rwReg [4];
  wire        sdoLine;
  int         mismatches = 0;
  int         checked = 0;
  int         cycles = 0;

  // Pull-up: a released line reads 1, never a stale bit
  assign sdoLine = serialDataOutEn ? serialDataOut : 1'b1;

  spc_port u_spc_port (
    .clk(clk), .rst_n(rst_n), .chipSelectN(chipSelectN), .serialClk(serialClk),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOutEn(serialDataOutEn),
    .faultSummary(roReg[0]), .ocFaultSummary(roReg[1]), .nocFaultSummary(roReg[2]),
    .opStatus(roReg[3]), .pinConfig1(roReg[4]), .pinConfig2(roReg[5]),
    .dacLow(rwReg[0]), .dacHigh(rwReg[1]), .dacCurrent(rwReg[2]), .spreadConfig(rwReg[3]),
    .writeProtect(writeProtect), .commFaultFlag(commFaultFlag), .wrLogValid(wrLogValid),
    .wrLogReady(wrLogReady), .wrLogAddr(wrLogAddr), .wrLogData(wrLogData));

  spc_master u_spc_master (.clk(clk), .chipSelectN(chipSelectN), .serialClk(serialClk),
    .serialDataIn(serialDataIn), .sdoLine(sdoLine));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  // Run needs about 6700 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] flip, input int n = 24);
    logic [23:0] rx;
    u_spc_master.burst({a, 1'b0, d, u_spc_master.packet_error_code({a, 1'b0, d}) ^ flip}, n, rx);
    `CHK("sdo on write", 24'hFFFFFF, rx)
    `CHK("sdo en", 1'b0, serialDataOutEn)
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [23:0] rx;
    u_spc_master.burst({a, 1'b1, 16'h0000}, 24, rx);
    `CHK("rd data", {8'hFF, e}, rx[23:8])
    `CHK("rd pec", u_spc_master.packet_error_code({a, 1'b1, e}), rx[7:0])
  endtask : rd

  task automatic t_regs();
    `CHK("idle en", 1'b0, serialDataOutEn)
    `CHK("rst log", 1'b0, wrLogValid)
    for (int i = 0; i < 4; i++) `CHK("rst reg", 8'h00, rwReg[i])
    for (int i = 0; i < 4; i++) wr(spc_pkg::ADDR_DAC0 + 7'(i), 8'hC3 ^ 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) begin
      `CHK("rw reg", 8'hC3 ^ 8'(i), rwReg[i])
      rd(spc_pkg::ADDR_DAC0 + 7'(i), 8'hC3 ^ 8'(i));
    end
    for (int i = 0; i < 6; i++) begin
      roReg[i] <= 8'h5A + 8'(i * 17);
      rd(spc_pkg::ADDR_FAULT + 7'(i), 8'h5A + 8'(i * 17));
    end
    rd(7'h0C, 8'h00);
  endtask : t_regs

  task automatic t_bad_pec();
    wr(spc_pkg::ADDR_DAC0, 8'h99, 8'h80);
    `CHK("bad pec", 8'hC3, rwReg[0])
    `CHK("fault set", 1'b1, commFaultFlag)
    rd(spc_pkg::ADDR_CTRL, 8'h04);
    wr(spc_pkg::ADDR_CTRL, 8'h04, 8'h00);
    `CHK("fault clr", 1'b0, commFaultFlag)
  endtask : t_bad_pec

  task automatic t_protect();
    wr(spc_pkg::ADDR_CTRL, 8'h01, 8'h00);
    `CHK("wp", 1'b1, writeProtect)
    rd(spc_pkg::ADDR_CTRL, 8'h01);
    for (int i = 0; i < 4; i++) wr(spc_pkg::ADDR_DAC0 + 7'(i), 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) `CHK("wp reg", 8'hC3 ^ 8'(i), rwReg[i])
    `CHK("wp fault", 1'b0, commFaultFlag)
    wr(spc_pkg::ADDR_CTRL, 8'h03, 8'h00);
    for (int i = 0; i < 4; i++) `CHK("clr reg", 8'h00, rwReg[i])
    `CHK("clr wp", 1'b0, writeProtect)
  endtask : t_protect

  task automatic t_short();
    wr(spc_pkg::ADDR_DAC0, 8'h11, 8'h00, 23);
    `CHK("short", 8'h00, rwReg[0])
    wr(spc_pkg::ADDR_DAC0, 8'h11, 8'h00);
    `CHK("after short", 8'h11, rwReg[0])
  endtask : t_short

  // Log stalled: four fit, the fifth is refused
  task automatic t_fifo();
    `CHK("log empty", 1'b0, wrLogValid)
    wrLogReady <= 1'b0;
    for (int i = 0; i < 5; i++) wr(spc_pkg::ADDR_DAC0 + 7'h01, 8'h40 + 8'(i), 8'h00);
    `CHK("full reg", 8'h43, rwReg[1])
    `CHK("full fault", 1'b1, commFaultFlag)
    for (int i = 0; i < 4; i++) begin
      `CHK("log valid", 1'b1, wrLogValid)
      `CHK("log addr", spc_pkg::ADDR_DAC0 + 7'h01, wrLogAddr)
      `CHK("log data", 8'h40 + 8'(i), wrLogData)
      wrLogReady <= 1'b1;
      @(posedge clk);
      wrLogReady <= 1'b0;
      @(posedge clk);
    end
    `CHK("log drained", 1'b0, wrLogValid)
    wrLogReady <= 1'b1;
    wr(spc_pkg::ADDR_CTRL, 8'h04, 8'h00);
    `CHK("fault clr", 1'b0, commFaultFlag)
  endtask : t_fifo

  initial begin
    rst_n = 1'b0;
    wrLogReady = 1'b1;
    for (int i = 0; i < 6; i++) roReg[i] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_bad_pec();
    t_protect();
    t_short();
    t_fifo();
    final_report();
  end
endmodule : spc_port_test
